// ---- idrc_defines.vh ----
// Constants for the identification and rate configuration block.
// Assumes inclusion by bare name from the same folder.
`ifndef IDRC_DEFINES_VH
`define IDRC_DEFINES_VH
// Register indices and byte addresses (index times four)
`define IDRC_IDX_IDENT        8'h00
`define IDRC_IDX_CFG1         8'h01
`define IDRC_ADDR_IDENT       10'h000
`define IDRC_ADDR_CFG1        10'h004
// Identification layout
`define IDRC_ID_FAMILY_LSB    5
`define IDRC_ID_HIGH_BIT      4
`define IDRC_ID_LOW_BIT       3
`define IDRC_ID_CHAN_HI_BIT   2
`define IDRC_ID_RESERVED_CNT  2'h3
// Configuration one layout
`define IDRC_CFG_READBACK_BIT 6
`define IDRC_CFG_OSC_OUT_BIT  5
`define IDRC_CFG_RATE_MSB     2
`define IDRC_CFG_WMASK        8'h67
`define IDRC_CFG1_RESET       8'h04
`define IDRC_RATE_FORBIDDEN   3'h7
`define IDRC_RATE_DEFAULT     3'h4
// Bus response codes
`define IDRC_RESP_OKAY        2'h0
`define IDRC_RESP_SLVERR      2'h2
// Last count of the modulator prescaler
`define IDRC_MOD_LAST         4'hf
// Modulator clock is master clock over 16
`define IDRC_MOD_DIV_LOG2     4
// Rate divide base is 16, i.e. 2^4 at code 000
`define IDRC_RATE_BASE_LOG2   4
`endif

// ---- idrc_divider.v ----
// Free-running divider producing data-ready strobes from a clock enable.
// Assumes tick_i is a one-cycle pulse in the clk_i domain.
`timescale 1ns/1ns
module idrc_divider
#(
  parameter WIDTH = 10
)
(
  input  wire             clk_i,
  input  wire             rst_i,
  input  wire             tick_i,
  input  wire [WIDTH-1:0] limit_i,
  output reg              pulse_o
);
  reg [WIDTH-1:0] count;

  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      count   <= {WIDTH{1'b0}};
      pulse_o <= 1'b0;
    end
    else
    begin
      pulse_o <= 1'b0;
      if (tick_i)
      begin
        // Restart if the limit shrank under the count
        if (count >= limit_i)
        begin
          count   <= {WIDTH{1'b0}};
          pulse_o <= 1'b1;
        end
        else
        begin
          count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // idrc_divider

// ---- idrc_host.sv ----
// Host model: Avalon-MM master making single register transfers.
// Assumes the slave answers through waitrequest on clk_i.
`timescale 1ns/1ns
module idrc_host
(
  input  wire         clk_i,
  input  wire [31:0]  readdata_i,
  input  wire [1:0]   response_i,
  input  wire         waitrequest_i,
  output logic [9:0]  address_o = 10'h000,
  output logic        read_o = 1'b0,
  output logic        write_o = 1'b0,
  output logic [3:0]  byteenable_o = 4'h0,
  output logic [31:0] writedata_o = 32'h0000_0000
);
  logic [31:0] rdata;
  logic [1:0]  resp;
  task automatic xfer(input logic wr, input logic [9:0] a,
                      input logic [7:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk_i);
    address_o <= a;
    byteenable_o <= be;
    writedata_o <= {24'h00_0000, d}; // Callers keep bits 7, 4, 3 clear in writes to 004h
    write_o <= wr;
    read_o <= !wr;
    do
    begin
      @(posedge clk_i);
      n++;
    end while (waitrequest_i && n < 50);
    if (waitrequest_i)
    begin
      tb_top.n_mismatch++;
      tb_top.conclude;
    end
    rdata = readdata_i;
    resp = response_i;
    read_o <= 1'b0;
    write_o <= 1'b0;
    // Released lines show garbage, not the last value
    address_o <= ~a;
    writedata_o <= ~writedata_o;
  endtask
endmodule // idrc_host

// ---- idrc_props.sv ----
// Port checker for the identification and rate configuration block.
// Assumes a bind from tb_top and the single clk_i domain.
`timescale 1ns/1ns
module idrc_props
#(
  parameter [2:0] FAMILY_CODE = 3'h2
)
(
  input wire        clk_i,
  input wire        rst_i,
  input wire [9:0]  avs_address_i,
  input wire        avs_read_i,
  input wire        avs_write_i,
  input wire [3:0]  avs_byteenable_i,
  input wire [31:0] avs_writedata_i,
  input wire [31:0] avs_readdata_o,
  input wire [1:0]  avs_response_o,
  input wire        avs_waitrequest_o,
  input wire        clock_source_pin_i,
  input wire        readback_mode_o,
  input wire        osc_out_en_o,
  input wire        clk_pin_o,
  input wire [2:0]  output_rate_select_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence id_rd_s;
    avs_read_i && !avs_waitrequest_o && avs_address_i == 10'h000;
  endsequence
  sequence cfg_wr_s;
    avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0] &&
      avs_address_i == 10'h004;
  endsequence
  property mode_p;
    logic [7:0] d;
    (cfg_wr_s, d = avs_writedata_i[7:0]) |-> ##2 readback_mode_o == d[6];
  endproperty
  // Forbidden code falls back to the default divide
  property rate_p;
    logic [2:0] c;
    (cfg_wr_s, c = avs_writedata_i[2:0]) |->
      ##2 output_rate_select_o == ((c == 3'h7) ? 3'h4 : c);
  endproperty
  id_fixed_a: assert property (
    id_rd_s |-> avs_readdata_o[4:2] == 3'h5) else $error("ident fixed bits");
  id_family_a: assert property (
    id_rd_s |-> avs_readdata_o[7:5] == FAMILY_CODE &&
    avs_readdata_o[1:0] != 2'h3) else $error("ident codes wrong");
  mode_follow_a: assert property (mode_p)
    else $error("readback mode wrong");
  rate_follow_a: assert property (rate_p)
    else $error("rate select wrong");
  bad_addr_a: assert property (!avs_waitrequest_o &&
    avs_address_i != 10'h000 && avs_address_i != 10'h004 |->
    avs_response_o == 2'h2) else $error("unmapped not refused");
  ack_time_a: assert property ($rose(avs_read_i || avs_write_i) |->
    ##1 !avs_waitrequest_o) else $error("answer late");
  osc_gate_a: assert property (
    !clock_source_pin_i [*4] |-> !osc_out_en_o) else $error("osc gate");
  clk_pin_a: assert property (
    !osc_out_en_o [*2] |-> !clk_pin_o) else $error("clock pin driven");
endmodule // idrc_props

// ---- idrc_regs.v ----
// Identification and global rate configuration registers with rate timing.
// Assumes an Avalon-MM master on clk_i; clock_source_pin is asynchronous.
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ns
`include "idrc_defines.vh"
// Function
// - Identification register at index 00h is fixed and ignores writes.
// - Top three identification bits always return the fixed family code.
// - Identification bit 4 reads one, bit 3 reads zero.
// - Identification bit 2 always reads one.
// - Bits 1:0 give channel count; pattern 11 is never reported.
// - Bit 6 picks daisy-chain at 0 (default), multiple readback at 1.
// - Bit 5 drives oscillator onto clock pin when source pin high.
// - Rate code divides modulator clock 16..1024; default 100; 111 banned.
module idrc_regs
#(
  parameter [2:0] FAMILY_CODE   = 3'h2, // Arbitrary value
  parameter [1:0] CHANNEL_CODE  = 2'h3  // Arbitrary value
)
(
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire [9:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [3:0]  avs_byteenable_i,
  input  wire [31:0] avs_writedata_i,
  output reg  [31:0] avs_readdata_o,
  output reg  [1:0]  avs_response_o,
  output reg         avs_waitrequest_o,
  input  wire        clock_source_pin_i,
  input  wire        osc_clk_i,
  output reg         readback_mode_o,
  output reg         osc_out_en_o,
  output reg         clk_pin_o,
  output reg  [2:0]  output_rate_select_o,
  output reg         modulator_clock_o,
  output reg         data_ready_o,
  output reg         rate_error_o
);
  localparam ST_IDLE = 1'b0;
  localparam ST_DONE = 1'b1;

  reg        state;
  reg [7:0]  cfg1;
  reg        pin_meta;
  reg        pin_sync;
  reg        osc_meta;
  reg        osc_sync;
  reg [3:0]  mod_count;
  reg        mod_tick;
  reg [7:0]  next_cfg1;
  reg [7:0]  ident;
  reg [31:0] next_rdata;
  reg [1:0]  next_resp;
  wire       hit_ident;
  wire       hit_cfg1;
  wire       ready_pulse;
  wire       cfg_commit;

  // Only lane zero carries the register, so only it qualifies a write
  function cfg_write_hit;
    input       wr;
    input [9:0] addr;
    input [3:0] be;
    begin
      cfg_write_hit = wr && (addr == `IDRC_ADDR_CFG1) && be[0];
    end
  endfunction

  function rate_forbidden;
    input [2:0] code;
    begin
      rate_forbidden = (code == `IDRC_RATE_FORBIDDEN);
    end
  endfunction

  // Sanitise a written rate: forbidden code falls back to the default
  function [2:0] legal_rate;
    input [2:0] code;
    begin
      if (rate_forbidden(code))
        legal_rate = `IDRC_RATE_DEFAULT;
      else
        legal_rate = code;
    end
  endfunction

  // Divide ratio in modulator ticks, minus one, for a rate code
  function [9:0] rate_limit;
    input [2:0] code;
    reg   [10:0] span;
    begin
      span       = 11'h010 << code;
      rate_limit = span[9:0] - 10'h001;
    end
  endfunction

  // Fixed-zero bits stay zero even if the host breaks the rule
  function [7:0] clean_cfg;
    input [7:0] data;
    begin
      clean_cfg      = data & `IDRC_CFG_WMASK;
      clean_cfg[2:0] = legal_rate(data[2:0]);
    end
  endfunction

  assign hit_ident = (avs_address_i == `IDRC_ADDR_IDENT);
  assign hit_cfg1  = (avs_address_i == `IDRC_ADDR_CFG1);
  // Commit on the accept edge, the one where waitrequest is seen low
  assign cfg_commit = (state == ST_DONE) &&
                      cfg_write_hit(avs_write_i, avs_address_i,
                                    avs_byteenable_i);

  always @*
  begin
    ident = 8'h00;
    ident[7:`IDRC_ID_FAMILY_LSB] = FAMILY_CODE;
    ident[`IDRC_ID_HIGH_BIT] = 1'b1;
    ident[`IDRC_ID_LOW_BIT] = 1'b0;
    ident[`IDRC_ID_CHAN_HI_BIT] = 1'b1;
    // Reserved channel pattern is replaced by the lowest count
    if (CHANNEL_CODE == `IDRC_ID_RESERVED_CNT)
      ident[1:0] = 2'h0;
    else
      ident[1:0] = CHANNEL_CODE;
  end

  always @*
  begin
    next_cfg1 = cfg1;
    if (cfg_commit)
    begin
      next_cfg1 = clean_cfg(avs_writedata_i[7:0]);
    end
  end

  always @*
  begin
    next_rdata = 32'h0000_0000;
    next_resp  = `IDRC_RESP_OKAY;
    if (hit_ident)
      next_rdata = {24'h00_0000, ident};
    else if (hit_cfg1)
      next_rdata = {24'h00_0000, cfg1};
    else
      next_resp = `IDRC_RESP_SLVERR;
  end

  // One wait cycle per access keeps readdata registered
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state             <= ST_IDLE;
      cfg1              <= `IDRC_CFG1_RESET;
      avs_readdata_o    <= 32'h0000_0000;
      avs_response_o    <= `IDRC_RESP_OKAY;
      avs_waitrequest_o <= 1'b1;
    end
    else
    begin
      // Identification is never a write target
      cfg1 <= next_cfg1;
      case (state)
        ST_IDLE:
        begin
          if (avs_read_i || avs_write_i)
          begin
            state             <= ST_DONE;
            avs_waitrequest_o <= 1'b0;
            // Registered now so the data stand at the accept edge
            avs_readdata_o    <= avs_read_i ? next_rdata : 32'h0000_0000;
            avs_response_o    <= next_resp;
          end
          else
          begin
            avs_waitrequest_o <= 1'b1;
          end
        end
        ST_DONE:
        begin
          // Accept edge: a write commits here and the master lets go
          state             <= ST_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
        default:
        begin
          state             <= ST_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
      endcase
    end
  end

  // Pin may change at any time; two flops settle it before use
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
    end
    else
    begin
      pin_meta <= clock_source_pin_i;
      pin_sync <= pin_meta;
    end
  end

  // Oscillator runs free of clk_i, so it is resampled the same way
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
    end
    else
    begin
      osc_meta <= osc_clk_i;
      osc_sync <= osc_meta;
    end
  end

  // Modulator tick every 16 master clocks; clk_i stands in for master
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mod_count <= 4'h0;
      mod_tick  <= 1'b0;
    end
    else
    begin
      mod_count <= mod_count + 4'h1;
      mod_tick  <= (mod_count == `IDRC_MOD_LAST);
    end
  end

  // Square wave at the modulator rate, high for the upper half count
  always @(posedge clk_i)
  begin
    if (rst_i)
      modulator_clock_o <= 1'b0;
    else
      modulator_clock_o <= mod_count[`IDRC_MOD_DIV_LOG2-1];
  end

  idrc_divider #(
    .WIDTH (10)
  ) u_rate (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .tick_i  (mod_tick),
    .limit_i (rate_limit(cfg1[`IDRC_CFG_RATE_MSB:0])),
    .pulse_o (ready_pulse)
  );

  // Mode and rate follow the register one clock later
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      readback_mode_o      <= 1'b0;
      output_rate_select_o <= `IDRC_RATE_DEFAULT;
    end
    else
    begin
      readback_mode_o      <= cfg1[`IDRC_CFG_READBACK_BIT];
      output_rate_select_o <= cfg1[`IDRC_CFG_RATE_MSB:0];
    end
  end

  // Output only when internal source selected and enabled
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      osc_out_en_o <= 1'b0;
      clk_pin_o    <= 1'b0;
    end
    else
    begin
      osc_out_en_o <= pin_sync & cfg1[`IDRC_CFG_OSC_OUT_BIT];
      // Resampled oscillator: its edges jitter by up to one clk_i period
      clk_pin_o    <= pin_sync & cfg1[`IDRC_CFG_OSC_OUT_BIT] &
                      osc_sync;
    end
  end

  // Strobe registered so the output comes straight from a flip-flop
  always @(posedge clk_i)
  begin
    if (rst_i)
      data_ready_o <= 1'b0;
    else
      data_ready_o <= ready_pulse;
  end

  // Flag follows the code of the latest accepted configuration write
  always @(posedge clk_i)
  begin
    if (rst_i)
      rate_error_o <= 1'b0;
    else if (cfg_commit)
      rate_error_o <= rate_forbidden(avs_writedata_i[2:0]);
  end
endmodule // idrc_regs

// ---- tb_top.sv ----
// Self-checking bench of the identification and rate block.
// Assumes idrc_regs, idrc_host and idrc_props are compiled first.
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_mismatch++; \
  $display("mismatch at %0t: %h vs %h", $time, a, b); end end
module tb_top;
  logic clk_i = 0, rst_i = 1, clock_source_pin_i = 0, osc_clk_i = 0;
  logic [9:0] avs_address_i;
  logic avs_read_i, avs_write_i, avs_waitrequest_o, readback_mode_o;
  logic osc_out_en_o, clk_pin_o, modulator_clock_o, data_ready_o;
  logic rate_error_o;
  logic [3:0] avs_byteenable_i;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic [1:0] avs_response_o;
  logic [2:0] output_rate_select_o;
  int n_mismatch = 0;
  int comparisons = 0;
  always #2 clk_i = ~clk_i;
  always #7 osc_clk_i = ~osc_clk_i;
  idrc_regs #(.CHANNEL_CODE(2'h2)) i_idrc_regs (.clk_i, .rst_i,
    .avs_address_i, .avs_read_i, .avs_write_i, .avs_byteenable_i,
    .avs_writedata_i, .avs_readdata_o, .avs_response_o, .avs_waitrequest_o,
    .clock_source_pin_i, .osc_clk_i, .readback_mode_o, .osc_out_en_o,
    .clk_pin_o, .output_rate_select_o, .modulator_clock_o, .data_ready_o,
    .rate_error_o);
  idrc_host i_idrc_host (.clk_i, .readdata_i(avs_readdata_o),
    .response_i(avs_response_o), .waitrequest_i(avs_waitrequest_o),
    .address_o(avs_address_i), .read_o(avs_read_i), .write_o(avs_write_i),
    .byteenable_o(avs_byteenable_i), .writedata_o(avs_writedata_i));
  task t_ident;
    i_idrc_host.xfer(1'b0, 10'h000, 8'h00, 4'h1);
    `CHK(i_idrc_host.rdata, 32'h0000_0056)
    i_idrc_host.xfer(1'b1, 10'h000, 8'hA9, 4'h1);
    i_idrc_host.xfer(1'b0, 10'h000, 8'h00, 4'h1);
    `CHK(i_idrc_host.rdata, 32'h0000_0056)
    $display("t_ident done");
  endtask
  task t_cfg;
    logic [7:0] v;
    i_idrc_host.xfer(1'b0, 10'h004, 8'h00, 4'h1);
    `CHK(i_idrc_host.rdata, 32'h0000_0004)
    for (int c = 0; c < 7; c++)
    begin
      v = {1'b0, c[0], c[1], 2'b00, c[2:0]};
      i_idrc_host.xfer(1'b1, 10'h004, v, 4'h1);
      i_idrc_host.xfer(1'b0, 10'h004, 8'h00, 4'h1);
      `CHK(i_idrc_host.rdata, {24'h00_0000, v})
      `CHK(readback_mode_o, v[6])
      `CHK(output_rate_select_o, v[2:0])
    end
    $display("t_cfg done");
  endtask
  task t_bad;
    i_idrc_host.xfer(1'b1, 10'h004, 8'h07, 4'h1);
    i_idrc_host.xfer(1'b0, 10'h004, 8'h00, 4'h1);
    `CHK(i_idrc_host.rdata, 32'h0000_0004)
    `CHK(rate_error_o, 1'b1)
    `CHK(i_idrc_host.resp, 2'h0)
    i_idrc_host.xfer(1'b1, 10'h004, 8'h40, 4'h0);
    i_idrc_host.xfer(1'b0, 10'h004, 8'h00, 4'h1);
    `CHK(i_idrc_host.rdata, 32'h0000_0004)
    i_idrc_host.xfer(1'b0, 10'h008, 8'h00, 4'h1);
    `CHK(i_idrc_host.resp, 2'h2)
    `CHK(i_idrc_host.rdata, 32'h0000_0000)
    $display("t_bad done");
  endtask
  task t_osc;
    int n;
    clock_source_pin_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    `CHK(osc_out_en_o, 1'b0)
    `CHK(clk_pin_o, 1'b0)
    i_idrc_host.xfer(1'b1, 10'h004, 8'h20, 4'h1);
    repeat (4) @(posedge clk_i);
    `CHK(osc_out_en_o, 1'b1)
    `CHK(rate_error_o, 1'b0)
    for (n = 0; n < 10 && !clk_pin_o; n++) @(posedge clk_i);
    `CHK(clk_pin_o, 1'b1)
    clock_source_pin_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    `CHK(osc_out_en_o, 1'b0)
    `CHK(clk_pin_o, 1'b0)
    $display("t_osc done");
  endtask
  task t_rate;
    int n;
    i_idrc_host.xfer(1'b1, 10'h004, 8'h00, 4'h1);
    // Code 000 period set by t_osc may still be running out
    for (n = 0; n < 17000 && !data_ready_o; n++) @(posedge clk_i);
    @(posedge clk_i);
    for (n = 1; n < 600 && !data_ready_o; n++) @(posedge clk_i);
    `CHK(n, 256)
    for (n = 0; n < 40 && modulator_clock_o; n++) @(posedge clk_i);
    for (n = 0; n < 40 && !modulator_clock_o; n++) @(posedge clk_i);
    for (n = 0; n < 40 && modulator_clock_o; n++) @(posedge clk_i);
    `CHK(n, 8)
    $display("t_rate done");
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    t_ident;
    t_cfg;
    t_bad;
    t_osc;
    t_rate;
    conclude;
  end
endmodule // tb_top
bind idrc_regs idrc_props #(.FAMILY_CODE(FAMILY_CODE)) i_idrc_props (.clk_i,
  .rst_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_byteenable_i,
  .avs_writedata_i, .avs_readdata_o, .avs_response_o, .avs_waitrequest_o,
  .clock_source_pin_i, .readback_mode_o, .osc_out_en_o, .clk_pin_o,
  .output_rate_select_o);
